/* File: rsvs_chk.sv */
// Port assertions for the reset and vector select block.
`timescale 1ns/1ps
module rsvs_chk #(
  parameter int ADDR_W = 16
) (
  // Watched ports.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic por_src_in,
  input wire logic ext_src_in,
  input wire logic bod_src_in,
  input wire logic wdt_src_in,
  input wire logic [2:0] brownout_level_fuses_in,
  input wire logic comparator_bandgap_select_in,
  input wire logic converter_enable_in,
  input wire logic app_side_boot_lock_in,
  input wire logic exec_in_boot_in,
  input wire logic [ADDR_W-1:0] boot_start_addr_in,
  input wire logic port_reset_out,
  input wire logic io_reset_out,
  input wire logic [ADDR_W-1:0] reset_vector_out,
  input wire logic [ADDR_W-1:0] vector_base_out,
  input wire logic irq_block_out,
  input wire logic bandgap_enable_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  port_pins_a: assert property (por_src_in || ext_src_in || bod_src_in || wdt_src_in |->
    port_reset_out) else $error("port reset missing");
  io_hold_a: assert property (port_reset_out |-> ##[1:4] io_reset_out)
    else $error("io reset not applied");
  stretch_min_a: assert property ($fell(io_reset_out) |-> !$past(port_reset_out, 4))
    else $error("internal reset not stretched");
  vec_fixed_a: assert property (reset_vector_out == '0) else $error("reset vector moved");
  vec_base_a: assert property (vector_base_out == '0 ||
    vector_base_out == boot_start_addr_in) else $error("vector base wrong");
  bandgap_on_a: assert property (bandgap_enable_out == (brownout_level_fuses_in != 3'h7 ||
    comparator_bandgap_select_in || converter_enable_in)) else $error("bandgap wrong");
  app_lock_a: assert property (vector_base_out == boot_start_addr_in &&
    boot_start_addr_in != '0 && app_side_boot_lock_in && !exec_in_boot_in |-> irq_block_out)
    else $error("lock block missing");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
  resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  cover property (irq_block_out);
  cover property ($fell(io_reset_out));
  cover property (vector_base_out == boot_start_addr_in && boot_start_addr_in != '0);
endmodule
bind rsvs_top rsvs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: rsvs_core_model.sv */
// Core model that retires one instruction every third cycle.
`timescale 1ns/1ps
module rsvs_core_model (
  // Clock, reset and retire pulse.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  output logic instr_done_out
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || cnt_ff == 2'h2) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  end
  assign instr_done_out = (cnt_ff == 2'h2);
endmodule

/* File: rsvs_map.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef RSVS_MAP_SVH
`define RSVS_MAP_SVH
`define RSVS_OFF_FLAGS 4'h0
`define RSVS_OFF_CTRL 4'h4
`define RSVS_OFF_IRQ_STAT 4'h8
`define RSVS_OFF_IRQ_MASK 4'hc
`define RSVS_BIT_WDOG_FLAG 3
`define RSVS_BIT_BROWN_FLAG 2
`define RSVS_BIT_EXT_FLAG 1
`define RSVS_BIT_POWER_FLAG 0
`define RSVS_BIT_VSEL 1
`define RSVS_BIT_VCE 0
`define RSVS_BIT_PULLUP_OFF 4
`define RSVS_FLAGS_MASK 8'h0f
`define RSVS_CTRL_MASK 8'h13
`define RSVS_CTRL_RESET 8'h00
`define RSVS_VCE_WINDOW 3'h4
`define RSVS_RESP_OKAY 2'h0
`define RSVS_RESP_SLVERR 2'h2
`endif

/* File: rsvs_pkg.sv */
// Types shared by the reset and vector select block.
package rsvs_pkg;
  typedef enum logic [1:0] {
    RSVS_ST_RESET = 2'b00,
    RSVS_ST_STRETCH = 2'b01,
    RSVS_ST_RUN = 2'b11
  } rsvs_state_type;
endpackage

/* File: rsvs_stretch.sv */
// Delay counter that stretches internal reset after the last source clears.
`timescale 1ns/1ps
module rsvs_stretch (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Control from the top.
  rsvs_stretch_if.cnt ctl_in
);
  logic [15:0] count_ff;
  logic busy_ff;
  logic [15:0] nxt_count;
  logic nxt_busy;
  wire cnt_zero = (count_ff == 16'h0000);
  assign ctl_in.done = busy_ff && cnt_zero;
  always_comb begin
    nxt_count = count_ff;
    nxt_busy = busy_ff;
    if (ctl_in.start) begin
      nxt_count = ctl_in.length;
      nxt_busy = 1'b1;
    end else if (busy_ff && !cnt_zero) begin
      nxt_count = count_ff - 16'h0001;
    end else if (busy_ff) begin
      nxt_busy = 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      busy_ff <= nxt_busy;
    end
  end
endmodule

/* File: rsvs_stretch_if.sv */
// Signals between the top and its reset stretch counter.
`timescale 1ns/1ps
interface rsvs_stretch_if;
  logic start;
  logic [15:0] length;
  logic done;
  modport ctl (output start, output length, input done);
  modport cnt (input start, input length, output done);
endinterface

/* File: rsvs_top.sv */
// Reset sequencing, reset cause flags, bandgap enable and vector placement.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "rsvs_map.svh"
module rsvs_top #(
  parameter int ADDR_W = 16,
  parameter logic [15:0] STRETCH_DEFAULT = 16'h0fff
) (
  // Clock and synchronous reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Reset sources, raw levels from outside the clock domain.
  input wire logic por_src_in,
  input wire logic ext_src_in,
  input wire logic bod_src_in,
  input wire logic wdt_src_in,
  // Configuration fuses and peripheral enables.
  input wire logic [1:0] startup_time_fuses_in,
  input wire logic [3:0] clock_select_fuses_in,
  input wire logic [2:0] brownout_level_fuses_in,
  input wire logic [ADDR_W-1:0] boot_start_addr_in,
  input wire logic app_side_boot_lock_in,
  input wire logic boot_side_boot_lock_in,
  input wire logic comparator_bandgap_select_in,
  input wire logic converter_enable_in,
  // Core status.
  input wire logic exec_in_boot_in,
  input wire logic instr_done_in,
  // Reset and control outputs.
  output logic port_reset_out,
  output logic io_reset_out,
  output logic [ADDR_W-1:0] reset_vector_out,
  output logic [ADDR_W-1:0] vector_base_out,
  output logic irq_block_out,
  output logic bandgap_enable_out,
  output logic pullup_disable_out,
  output logic irq_out,
  // AXI4-Lite slave.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////
  // Source synchronisers and the internal reset state machine.
  logic [3:0] src_meta_ff;
  logic [3:0] src_sync_ff;
  rsvs_pkg::rsvs_state_type state_ff;
  rsvs_pkg::rsvs_state_type nxt_state;
  rsvs_stretch_if stretch_bus ();
  wire any_src = |src_sync_ff;
  wire por_s = src_sync_ff[0];
  wire ext_s = src_sync_ff[1];
  wire bod_s = src_sync_ff[2];
  wire wdt_s = src_sync_ff[3];
  // Pins go to reset straight from the raw sources, with no clock needed.
  assign port_reset_out = por_src_in | ext_src_in | bod_src_in | wdt_src_in | sys_rst_in;
  assign io_reset_out = (state_ff != rsvs_pkg::RSVS_ST_RUN);
  assign reset_vector_out = {ADDR_W{1'b0}};
  assign stretch_bus.length = STRETCH_DEFAULT ^
    {10'h000, startup_time_fuses_in, clock_select_fuses_in};
  assign stretch_bus.start = (state_ff == rsvs_pkg::RSVS_ST_RESET) && !any_src;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rsvs_pkg::RSVS_ST_RESET: begin
        if (!any_src) nxt_state = rsvs_pkg::RSVS_ST_STRETCH;
      end
      rsvs_pkg::RSVS_ST_STRETCH: begin
        if (any_src) nxt_state = rsvs_pkg::RSVS_ST_RESET;
        else if (stretch_bus.done) nxt_state = rsvs_pkg::RSVS_ST_RUN;
      end
      rsvs_pkg::RSVS_ST_RUN: begin
        if (any_src) nxt_state = rsvs_pkg::RSVS_ST_RESET;
      end
      default: nxt_state = rsvs_pkg::RSVS_ST_RESET;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      src_meta_ff <= 4'h0;
      src_sync_ff <= 4'h0;
      state_ff <= rsvs_pkg::RSVS_ST_RESET;
    end else begin
      src_meta_ff <= {wdt_src_in, bod_src_in, ext_src_in, por_src_in};
      src_sync_ff <= src_meta_ff;
      state_ff <= nxt_state;
    end
  end
  rsvs_stretch u_stretch (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ctl_in(stretch_bus.cnt)
  );
  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read decode.
  logic aw_got_ff;
  logic w_got_ff;
  logic [3:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  wire wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_lane0 = wr_fire && w_strb_ff[0];
  wire wr_flags = wr_lane0 && (aw_addr_ff == `RSVS_OFF_FLAGS);
  wire wr_ctrl = wr_lane0 && (aw_addr_ff == `RSVS_OFF_CTRL);
  wire wr_stat = wr_lane0 && (aw_addr_ff == `RSVS_OFF_IRQ_STAT);
  wire wr_mask = wr_lane0 && (aw_addr_ff == `RSVS_OFF_IRQ_MASK);
  wire wr_hit = (aw_addr_ff == `RSVS_OFF_FLAGS) || (aw_addr_ff == `RSVS_OFF_CTRL) ||
    (aw_addr_ff == `RSVS_OFF_IRQ_STAT) || (aw_addr_ff == `RSVS_OFF_IRQ_MASK);
  wire [7:0] wbyte = w_data_ff[7:0];
  wire rd_fire = s_axi_arvalid && !rvalid_ff;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RSVS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `RSVS_RESP_OKAY : `RSVS_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Reset cause flags.
  logic [3:0] flags_ff;
  logic [3:0] nxt_flags;
  logic [3:0] src_prev_ff;
  wire [3:0] src_rise = src_sync_ff & ~src_prev_ff;
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_flags) nxt_flags = flags_ff & wbyte[3:0];
    if (por_s) begin
      nxt_flags[`RSVS_BIT_WDOG_FLAG] = 1'b0;
      nxt_flags[`RSVS_BIT_BROWN_FLAG] = 1'b0;
      nxt_flags[`RSVS_BIT_EXT_FLAG] = 1'b0;
    end
    // A new reset event beats a simultaneous software clear.
    if (wdt_s && !por_s) nxt_flags[`RSVS_BIT_WDOG_FLAG] = 1'b1;
    if (bod_s && !por_s) nxt_flags[`RSVS_BIT_BROWN_FLAG] = 1'b1;
    if (ext_s && !por_s) nxt_flags[`RSVS_BIT_EXT_FLAG] = 1'b1;
    if (por_s) nxt_flags[`RSVS_BIT_POWER_FLAG] = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // Vector placement control and the timed change window.
  logic vsel_ff;
  logic vce_ff;
  logic pud_ff;
  logic [2:0] vce_cnt_ff;
  logic [2:0] nxt_vce_cnt;
  logic nxt_vce;
  logic nxt_vsel;
  logic post_write_ff;
  logic nxt_post_write;
  wire vce_open = vce_ff && (vce_cnt_ff != 3'h0);
  wire vsel_write = wr_ctrl && !wbyte[`RSVS_BIT_VCE] && vce_open;
  always_comb begin
    nxt_vce = vce_ff;
    nxt_vce_cnt = vce_cnt_ff;
    nxt_vsel = vsel_ff;
    nxt_post_write = post_write_ff;
    if (vce_ff) nxt_vce_cnt = vce_cnt_ff - 3'h1;
    if (vce_ff && vce_cnt_ff == 3'h1) nxt_vce = 1'b0;
    if (post_write_ff && instr_done_in) nxt_post_write = 1'b0;
    if (wr_ctrl && wbyte[`RSVS_BIT_VCE]) begin
      nxt_vce = 1'b1;
      nxt_vce_cnt = `RSVS_VCE_WINDOW;
    end else if (vsel_write) begin
      nxt_vsel = wbyte[`RSVS_BIT_VSEL];
      nxt_vce = 1'b0;
      nxt_vce_cnt = 3'h0;
      nxt_post_write = 1'b1;
    end
  end
  // Blocking is a separate gate; the core's global enable is never written.
  wire lock_block = (vsel_ff && app_side_boot_lock_in && !exec_in_boot_in) ||
    (!vsel_ff && boot_side_boot_lock_in && exec_in_boot_in);
  assign irq_block_out = vce_ff || post_write_ff || lock_block;
  assign vector_base_out = vsel_ff ? boot_start_addr_in : {ADDR_W{1'b0}};
  assign pullup_disable_out = pud_ff;
  assign bandgap_enable_out = (brownout_level_fuses_in != 3'b111) ||
    comparator_bandgap_select_in || converter_enable_in;
  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: reset-cause events, write one to clear.
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] nxt_stat;
  always_comb begin
    nxt_stat = irq_stat_ff;
    if (wr_stat) nxt_stat = irq_stat_ff & ~wbyte[3:0];
    nxt_stat = nxt_stat | src_rise;
  end
  assign irq_out = |(irq_stat_ff & irq_mask_ff);
  wire [7:0] ctrl_view = {3'b000, pud_ff, 2'b00, vsel_ff, vce_ff} & `RSVS_CTRL_MASK;
  wire [7:0] flags_view = {4'h0, flags_ff} & `RSVS_FLAGS_MASK;
  wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
  wire rd_hit = (rd_addr == `RSVS_OFF_FLAGS) || (rd_addr == `RSVS_OFF_CTRL) ||
    (rd_addr == `RSVS_OFF_IRQ_STAT) || (rd_addr == `RSVS_OFF_IRQ_MASK);
  wire [7:0] rd_byte = (rd_addr == `RSVS_OFF_FLAGS) ? flags_view :
    (rd_addr == `RSVS_OFF_CTRL) ? ctrl_view :
    (rd_addr == `RSVS_OFF_IRQ_STAT) ? {4'h0, irq_stat_ff} :
    (rd_addr == `RSVS_OFF_IRQ_MASK) ? {4'h0, irq_mask_ff} : 8'h00;
  // Flags live through sys_rst_in so the cause survives; only power-on or a software write to the flags clears.
  always_ff @(posedge clk_in) begin
    flags_ff <= nxt_flags;
    src_prev_ff <= src_sync_ff;
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || io_reset_out) begin
      vsel_ff <= 1'b0;
      vce_ff <= 1'b0;
      pud_ff <= 1'b0;
      vce_cnt_ff <= 3'h0;
      post_write_ff <= 1'b0;
      irq_mask_ff <= 4'h0;
    end else begin
      vsel_ff <= nxt_vsel;
      vce_ff <= nxt_vce;
      vce_cnt_ff <= nxt_vce_cnt;
      post_write_ff <= nxt_post_write;
      if (wr_ctrl) pud_ff <= wbyte[`RSVS_BIT_PULLUP_OFF];
      if (wr_mask) irq_mask_ff <= wbyte[3:0];
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= 4'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RSVS_RESP_OKAY;
    end else begin
      irq_stat_ff <= nxt_stat;
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h000000, rd_byte};
        rresp_ff <= rd_hit ? `RSVS_RESP_OKAY : `RSVS_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule

/* File: test_reset_status_vector_select.sv */
// Self-checking bench for the reset and vector select block.
`timescale 1ns/1ps
`include "rsvs_map.svh"
module test_reset_status_vector_select;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic por_src_in = 1'b1, ext_src_in = 1'b0, bod_src_in = 1'b0, wdt_src_in = 1'b0;
  logic [1:0] startup_time_fuses_in = 2'h0;
  logic [3:0] clock_select_fuses_in = 4'h0;
  logic [2:0] brownout_level_fuses_in = 3'h7;
  logic [15:0] boot_start_addr_in = 16'h1c00;
  logic app_side_boot_lock_in = 1'b0, boot_side_boot_lock_in = 1'b0, exec_in_boot_in = 1'b0;
  logic comparator_bandgap_select_in = 1'b0, converter_enable_in = 1'b0, instr_done_in;
  logic port_reset_out, io_reset_out, irq_block_out, bandgap_enable_out;
  logic pullup_disable_out, irq_out;
  logic [15:0] reset_vector_out, vector_base_out;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0, cmp_count = 0;
  always #10 clk_in = ~clk_in;
  rsvs_core_model u_core (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .instr_done_out(instr_done_in));
  rsvs_top #(.STRETCH_DEFAULT(16'h0010)) u_dut (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic stop_late;
    mismatches++;
    report_and_stop;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wait_run(output int n);
    for (n = 0; n < 300 && io_reset_out !== 1'b0; n++) @(posedge clk_in);
    if (n == 300) stop_late;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (s_axi_bvalid === 1'b1 && !s_axi_awvalid && !s_axi_wvalid) break;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    if (n == 40) stop_late;
    chk(s_axi_bresp, `RSVS_RESP_OKAY);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (s_axi_rvalid === 1'b1 && !s_axi_arvalid) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (n == 40) stop_late;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power;
    int n;
    chk(port_reset_out, 1'b1);
    // Power-on must outlast the source synchroniser to reach the flags.
    tick(3);
    por_src_in <= 1'b0;
    wait_run(n);
    chk(n >= 17, 1'b1);
    chk(reset_vector_out, 16'h0000);
    axr(`RSVS_OFF_FLAGS, 32'h1, `RSVS_RESP_OKAY);
    axr(`RSVS_OFF_CTRL, 32'h0, `RSVS_RESP_OKAY);
  endtask
  task automatic t_sources;
    int i;
    int n;
    logic irq_a;
    for (i = 1; i < 4; i++) begin
      axw(`RSVS_OFF_IRQ_STAT, 32'hf, 4'h1);
      ext_src_in <= (i == 1);
      bod_src_in <= (i == 2);
      wdt_src_in <= (i == 3);
      tick(4);
      chk(port_reset_out, 1'b1);
      ext_src_in <= 1'b0;
      bod_src_in <= 1'b0;
      wdt_src_in <= 1'b0;
      wait_run(n);
      axr(`RSVS_OFF_FLAGS, (32'h1 << i) | (i == 1), `RSVS_RESP_OKAY);
      axw(`RSVS_OFF_FLAGS, 32'hf0, 4'h1);
      axr(`RSVS_OFF_FLAGS, 32'h0, `RSVS_RESP_OKAY);
      axr(`RSVS_OFF_IRQ_STAT, 32'h1 << i, `RSVS_RESP_OKAY);
      axw(`RSVS_OFF_IRQ_MASK, 32'hf, 4'h1);
      irq_a = irq_out;
      chk(irq_a, 1'b1);
      axw(`RSVS_OFF_IRQ_MASK, 32'h0, 4'h1);
      chk(irq_out, 1'b0);
      axw(`RSVS_OFF_IRQ_MASK, 32'hf, 4'h1);
      axw(`RSVS_OFF_IRQ_STAT, 32'hf, 4'h1);
      chk(irq_out, 1'b0);
    end
    // A power-on that follows a watchdog reset leaves only the power-on flag.
    wdt_src_in <= 1'b1;
    tick(4);
    wdt_src_in <= 1'b0;
    por_src_in <= 1'b1;
    tick(4);
    por_src_in <= 1'b0;
    wait_run(n);
    axr(`RSVS_OFF_FLAGS, 32'h1, `RSVS_RESP_OKAY);
  endtask
  task automatic t_vec;
    axw(`RSVS_OFF_CTRL, 32'h1, 4'h1);
    chk(irq_block_out, 1'b1);
    tick(6);
    chk(irq_block_out, 1'b0);
    axw(`RSVS_OFF_CTRL, 32'h2, 4'h1);
    chk(vector_base_out, 16'h0);
    axw(`RSVS_OFF_CTRL, 32'h1, 4'h1);
    axw(`RSVS_OFF_CTRL, 32'h2, 4'h1);
    chk(vector_base_out, 16'h1c00);
    tick(4);
    chk(irq_block_out, 1'b0);
    app_side_boot_lock_in <= 1'b1;
    tick(1);
    chk(irq_block_out, 1'b1);
    exec_in_boot_in <= 1'b1;
    tick(1);
    chk(irq_block_out, 1'b0);
    app_side_boot_lock_in <= 1'b0;
    boot_side_boot_lock_in <= 1'b1;
    axw(`RSVS_OFF_CTRL, 32'h1, 4'h1);
    axw(`RSVS_OFF_CTRL, 32'h0, 4'h1);
    chk(vector_base_out, 16'h0);
    tick(4);
    chk(irq_block_out, 1'b1);
    exec_in_boot_in <= 1'b0;
    tick(1);
    chk(irq_block_out, 1'b0);
  endtask
  task automatic t_ctrl;
    int i;
    axw(`RSVS_OFF_CTRL, 32'h10, 4'h0);
    chk(pullup_disable_out, 1'b0);
    axw(`RSVS_OFF_CTRL, 32'hec, 4'h1);
    axr(`RSVS_OFF_CTRL, 32'h0, `RSVS_RESP_OKAY);
    axw(`RSVS_OFF_CTRL, 32'h10, 4'h1);
    chk(pullup_disable_out, 1'b1);
    axr(`RSVS_OFF_CTRL, 32'h10, `RSVS_RESP_OKAY);
    // The byte-offset bits are ignored, so this reads the control register.
    axr(4'h6, 32'h10, `RSVS_RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      brownout_level_fuses_in <= i[0] ? 3'h3 : 3'h7;
      comparator_bandgap_select_in <= i[1];
      converter_enable_in <= i[2];
      tick(1);
      chk(bandgap_enable_out, i != 0);
    end
  endtask
  initial begin
    tick(12);
    sys_rst_in <= 1'b0;
    t_power;
    t_sources;
    t_vec;
    t_ctrl;
    report_and_stop;
  end
endmodule
